// >>> shmac_pkg.sv
// Package for the signed halfword multiply-accumulate unit.
// Assumes one clock domain; operation codes come from the core's decoder.
package shmac_pkg;

  // ----------------------------------------------------------------
  // Operation codes
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    SHMAC_OP_DUAL_MAC32,
    SHMAC_OP_DUAL_MAC32_SWAPPED,
    SHMAC_OP_WORD_MAC64,
    SHMAC_OP_HALF_SELECT_MAC64,
    SHMAC_OP_DUAL_MAC64,
    SHMAC_OP_DUAL_MAC64_SWAPPED
  } shmac_op_t;

  // ----------------------------------------------------------------
  // Field layout and timing
  // ----------------------------------------------------------------
  localparam int          SHMAC_WORD_W     = 32;
  localparam int          SHMAC_HALF_W     = 16;
  localparam int          SHMAC_LO_LSB     = 0;
  localparam int          SHMAC_HI_LSB     = 16;
  localparam int          SHMAC_LATENCY    = 1;
  localparam logic [31:0] SHMAC_RESULT_RST = 32'h0000_0000;

endpackage : shmac_pkg

// >>> shmac_op_if.sv
// Interface carrying the routed operands and their product sum between the issue stage and the
// multiply core of the multiply-accumulate unit.
// Assumes both ends sit in the same clock domain.
`timescale 1ns/1ps
interface shmac_op_if;
  import shmac_pkg::*;
  logic        [31:0] prod_a;
  logic        [31:0] prod_b;
  logic signed [63:0] product_sum;

  modport issue (output prod_a, output prod_b, input  product_sum);
  modport core  (input  prod_a, input  prod_b, output product_sum);
endinterface : shmac_op_if

// >>> shmac_product.sv
// Combinational product stage of the multiply-accumulate unit.
// Assumes operands are already routed; it only forms signed products and, for the dual operations, their sum.
`timescale 1ns/1ps
module shmac_product
  import shmac_pkg::*;
(
  // Operation select
  input  wire shmac_op_t op,
  // Operand and product link
  shmac_op_if.core       link
);

  // ----------------------------------------------------------------
  // Halfword product helper
  // ----------------------------------------------------------------
  function automatic logic signed [31:0] shmac_hmul(input logic [15:0] a, input logic [15:0] b);
    shmac_hmul = $signed(a) * $signed(b);
  endfunction : shmac_hmul

  logic signed [63:0] word_prod;
  logic signed [31:0] top_prod;
  logic signed [31:0] bot_prod;

  always_comb begin
    word_prod = $signed(link.prod_a) * $signed(link.prod_b);
    top_prod  = shmac_hmul(link.prod_a[31:16], link.prod_b[31:16]);
    bot_prod  = shmac_hmul(link.prod_a[15:0], link.prod_b[15:0]);
    case (op)
      SHMAC_OP_WORD_MAC64: begin
        link.product_sum = word_prod;
      end
      SHMAC_OP_HALF_SELECT_MAC64: begin
        link.product_sum = 64'(bot_prod);
      end
      default: begin
        link.product_sum = 64'(top_prod) + 64'(bot_prod);
      end
    endcase
  end

endmodule : shmac_product

// >>> shmac_unit.sv
// Top of the signed halfword multiply-accumulate unit: operand routing,
// accumulation and the registered result.
// Assumes the core's decoder keeps to the register restrictions and holds
// flags itself; this unit has no flag outputs at all.
`timescale 1ns/1ps

module shmac_unit
  import shmac_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        srst,
  // Request from decode
  input  wire logic        op_valid,
  input  wire shmac_op_t   op,
  input  wire logic        first_top_sel,
  input  wire logic        second_top_sel,
  input  wire logic [31:0] first_operand_reg,
  input  wire logic [31:0] second_operand_reg,
  input  wire logic [31:0] accum_operand_reg,
  input  wire logic [31:0] acc_low_word_in,
  input  wire logic [31:0] acc_high_word_in,
  // Result to register file
  output logic             result_valid,
  output logic             result_is_long,
  output logic      [31:0] dest_low_word_reg,
  output logic      [31:0] dest_high_word_reg
);

  shmac_op_if link ();

  logic        [31:0] swapped_b;
  logic        [15:0] half_a;
  logic        [15:0] half_b;
  logic signed [63:0] sum64;
  logic signed [31:0] sum32;
  logic               next_valid;
  logic               next_long;
  logic        [31:0] next_low;
  logic        [31:0] next_high;

  // ----------------------------------------------------------------
  // Operand helpers
  // ----------------------------------------------------------------
  // Picks the top or the bottom halfword of a source word
  function automatic logic [15:0] shmac_half(input logic [31:0] w, input logic top);
    shmac_half = top ? w[SHMAC_HI_LSB +: SHMAC_HALF_W] : w[SHMAC_LO_LSB +: SHMAC_HALF_W];
  endfunction : shmac_half

  // True for the operations that write back the 64-bit pair
  function automatic logic shmac_is_long(input shmac_op_t o);
    shmac_is_long = !(o == SHMAC_OP_DUAL_MAC32 || o == SHMAC_OP_DUAL_MAC32_SWAPPED);
  endfunction : shmac_is_long

  // Signed halfword product, sign-extended to the pair width
  function automatic logic signed [63:0] shmac_hprod(input logic [15:0] x, input logic [15:0] y);
    shmac_hprod = 64'($signed(x) * $signed(y));
  endfunction : shmac_hprod

  // ----------------------------------------------------------------
  // Operand routing
  // ----------------------------------------------------------------
  always_comb begin
    // Crossing the second operand's halves gives the swapped pairing
    // with the same two halfword multipliers as the straight case
    swapped_b = {second_operand_reg[15:0], second_operand_reg[31:16]};
    half_a    = shmac_half(first_operand_reg, first_top_sel);
    half_b    = shmac_half(second_operand_reg, second_top_sel);
    case (op)
      SHMAC_OP_DUAL_MAC32_SWAPPED, SHMAC_OP_DUAL_MAC64_SWAPPED: begin
        link.prod_a = first_operand_reg;
        link.prod_b = swapped_b;
      end
      SHMAC_OP_HALF_SELECT_MAC64: begin
        link.prod_a = {16'h0000, half_a};
        link.prod_b = {16'h0000, half_b};
      end
      default: begin
        link.prod_a = first_operand_reg;
        link.prod_b = second_operand_reg;
      end
    endcase
  end

  shmac_product u_product (
    .op   (op),
    .link (link)
  );

  // ----------------------------------------------------------------
  // Accumulate, wrapping at the destination width
  // ----------------------------------------------------------------
  always_comb begin
    sum64      = link.product_sum + $signed({acc_high_word_in, acc_low_word_in});
    sum32      = link.product_sum[31:0] + $signed(accum_operand_reg);
    next_valid = op_valid;
    next_long  = shmac_is_long(op);
    next_low   = dest_low_word_reg;
    next_high  = dest_high_word_reg;
    if (op_valid) begin
      if (next_long) begin
        next_low  = sum64[31:0];
        next_high = sum64[63:32];
      end else begin
        next_low  = sum32;
        next_high = SHMAC_RESULT_RST;
      end
    end
    // No flag path exists: overflow is discarded silently.
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      result_valid       <= 1'b0;
      result_is_long     <= 1'b0;
      dest_low_word_reg  <= SHMAC_RESULT_RST;
      dest_high_word_reg <= SHMAC_RESULT_RST;
    end else begin
      result_valid       <= next_valid;
      result_is_long     <= next_long;
      dest_low_word_reg  <= next_low;
      dest_high_word_reg <= next_high;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  sequence s_dual32_plain;
    op_valid && op == SHMAC_OP_DUAL_MAC32;
  endsequence
  sequence s_dual32_swap;
    op_valid && op == SHMAC_OP_DUAL_MAC32_SWAPPED;
  endsequence

  sequence s_word64;
    op_valid && op == SHMAC_OP_WORD_MAC64;
  endsequence

  sequence s_half64;
    op_valid && op == SHMAC_OP_HALF_SELECT_MAC64;
  endsequence

  sequence s_dual64_plain;
    op_valid && op == SHMAC_OP_DUAL_MAC64;
  endsequence

  sequence s_dual64_swap;
    op_valid && op == SHMAC_OP_DUAL_MAC64_SWAPPED;
  endsequence

  sequence s_short_op;
    op_valid && !shmac_is_long(op);
  endsequence

  sequence s_long_op;
    op_valid && shmac_is_long(op);
  endsequence

  // A request with a quiet cycle after it
  sequence s_lone_op;
    op_valid ##1 !op_valid;
  endsequence

  // A one-cycle result strobe
  sequence s_lone_result;
    result_valid ##1 !result_valid;
  endsequence

  sequence s_two_ops;
    op_valid ##1 op_valid;
  endsequence

  dual_plain_sum_a: assert property (s_dual32_plain |=> result_valid && dest_low_word_reg ==
    32'($signed($past(first_operand_reg[31:16])) * $signed($past(second_operand_reg[31:16]))
      + $signed($past(first_operand_reg[15:0])) * $signed($past(second_operand_reg[15:0]))
      + $signed($past(accum_operand_reg))))
    else $error("dual plain sum wrong");
  dual_swap_sum_a: assert property (s_dual32_swap |=> dest_low_word_reg ==
    32'($signed($past(first_operand_reg[31:16])) * $signed($past(second_operand_reg[15:0]))
      + $signed($past(first_operand_reg[15:0])) * $signed($past(second_operand_reg[31:16]))
      + $signed($past(accum_operand_reg))))
    else $error("dual swapped sum wrong");
  dual32_short_a: assert property (s_short_op |=> result_valid && !result_is_long)
    else $error("dual 32 marked long");
  word_mac_a: assert property (op_valid && op == SHMAC_OP_WORD_MAC64 |=>
    {dest_high_word_reg, dest_low_word_reg} == 64'($signed($past(first_operand_reg))
      * $signed($past(second_operand_reg)) + $signed({$past(acc_high_word_in), $past(acc_low_word_in)})))
    else $error("word long accumulate wrong");
  half_sel_a: assert property (s_half64 |=>
    {dest_high_word_reg, dest_low_word_reg} == shmac_hprod(
      $past(first_top_sel) ? $past(first_operand_reg[31:16]) : $past(first_operand_reg[15:0]),
      $past(second_top_sel) ? $past(second_operand_reg[31:16]) : $past(second_operand_reg[15:0]))
      + {$past(acc_high_word_in), $past(acc_low_word_in)})
    else $error("half select accumulate wrong");
  half_pick_a: assert property (s_half64 |->
    link.product_sum == shmac_hprod(first_top_sel ? first_operand_reg[31:16] : first_operand_reg[15:0],
      second_top_sel ? second_operand_reg[31:16] : second_operand_reg[15:0]))
    else $error("half select picked wrong half");
  dual_long_a: assert property (op_valid && op == SHMAC_OP_DUAL_MAC64_SWAPPED |=>
    {dest_high_word_reg, dest_low_word_reg} == 64'($signed($past(first_operand_reg[31:16]))
      * $signed($past(second_operand_reg[15:0])) + $signed($past(first_operand_reg[15:0]))
      * $signed($past(second_operand_reg[31:16])) + $signed({$past(acc_high_word_in), $past(acc_low_word_in)})))
    else $error("dual long swapped wrong");
  hold_idle_a: assert property (!op_valid |=> !result_valid && $stable(dest_low_word_reg))
    else $error("result moved while idle");

  // ----------------------------------------------------------------
  // Checks on the product link
  // ----------------------------------------------------------------
  dual_plain_prod_a: assert property (s_dual32_plain |->
    link.product_sum == shmac_hprod(first_operand_reg[31:16], second_operand_reg[31:16])
      + shmac_hprod(first_operand_reg[15:0], second_operand_reg[15:0]))
    else $error("dual plain pairing wrong");

  dual_swap_prod_a: assert property (s_dual32_swap |->
    link.product_sum == shmac_hprod(first_operand_reg[31:16], second_operand_reg[15:0])
      + shmac_hprod(first_operand_reg[15:0], second_operand_reg[31:16]))
    else $error("dual swapped pairing wrong");

  long_plain_prod_a: assert property (s_dual64_plain |->
    link.product_sum == shmac_hprod(first_operand_reg[31:16], second_operand_reg[31:16])
      + shmac_hprod(first_operand_reg[15:0], second_operand_reg[15:0]))
    else $error("dual long plain pairing wrong");

  long_swap_prod_a: assert property (s_dual64_swap |->
    link.product_sum == shmac_hprod(first_operand_reg[31:16], second_operand_reg[15:0])
      + shmac_hprod(first_operand_reg[15:0], second_operand_reg[31:16]))
    else $error("dual long swapped pairing wrong");

  word_prod_a: assert property (s_word64 |->
    link.product_sum == 64'($signed(first_operand_reg) * $signed(second_operand_reg)))
    else $error("word product wrong");

  half_ext_a: assert property (s_half64 |->
    link.product_sum[63:32] == {32{link.product_sum[31]}})
    else $error("half select product not sign extended");

  // ----------------------------------------------------------------
  // Checks on the registered result
  // ----------------------------------------------------------------
  // The short sum keeps only the low 32 bits
  dual32_acc_a: assert property (s_short_op |=>
    dest_low_word_reg == $past(link.product_sum[31:0]) + $past(accum_operand_reg))
    else $error("dual 32 accumulate wrong");

  dual_high_zero_a: assert property (s_short_op |=> dest_high_word_reg == SHMAC_RESULT_RST)
    else $error("dual 32 high word not zero");

  dual_long_plain_a: assert property (s_dual64_plain |=>
    {dest_high_word_reg, dest_low_word_reg} == shmac_hprod($past(first_operand_reg[31:16]),
      $past(second_operand_reg[31:16])) + shmac_hprod($past(first_operand_reg[15:0]),
      $past(second_operand_reg[15:0])) + {$past(acc_high_word_in), $past(acc_low_word_in)})
    else $error("dual long plain wrong");

  long_flag_a: assert property (s_long_op |=> result_valid && result_is_long)
    else $error("long result not marked long");

  long_follow_a: assert property (op_valid |=> result_is_long == shmac_is_long($past(op)))
    else $error("long marker does not follow the operation");

  // Long sums wrap at 64 bits; no saturation stage exists
  long_wrap_a: assert property (s_long_op |=>
    {dest_high_word_reg, dest_low_word_reg}
      == 64'($past(link.product_sum) + {$past(acc_high_word_in), $past(acc_low_word_in)}))
    else $error("long accumulate does not wrap");

  lone_pulse_a: assert property (s_lone_op |-> s_lone_result)
    else $error("result strobe not a single pulse");

  back_to_back_a: assert property (s_two_ops |-> result_valid ##1 result_valid)
    else $error("back to back results lost");

  hold_pair_a: assert property (!op_valid |=> $stable(dest_high_word_reg) && $stable(dest_low_word_reg))
    else $error("pair moved while idle");

  // ----------------------------------------------------------------
  // Reset state
  // ----------------------------------------------------------------
  reset_clear_a: assert property (disable iff (1'b0) srst |=> !result_valid && !result_is_long
    && dest_low_word_reg == SHMAC_RESULT_RST && dest_high_word_reg == SHMAC_RESULT_RST)
    else $error("reset left a result behind");

endmodule : shmac_unit

// >>> shmac_regfile_model.sv
// Register-file model holding the 64-bit accumulator pair for long operations.
// Assumes the bench loads the pair and keeps register choices legal.
`timescale 1ns/1ps
module shmac_regfile_model (
  // Clock and load from the bench
  input  wire logic        clk,
  input  wire logic        load,
  input  wire logic [63:0] load_val,
  // Write-back from the unit
  input  wire logic        wb_en,
  input  wire logic [63:0] wb_val,
  // Pair towards the unit
  output logic      [31:0] pair_lo,
  output logic      [31:0] pair_hi
);
  // Separate low and high words, neither one a stack or program counter
  always_ff @(posedge clk) begin
    if (load)
      {pair_hi, pair_lo} <= load_val;
    else if (wb_en)
      {pair_hi, pair_lo} <= wb_val;
  end
endmodule : shmac_regfile_model

// >>> shmac_unit_tb.sv
// Self-checking bench for the multiply-accumulate unit.
// Assumes a 200 MHz clock and the register-file model for the pair.
`timescale 1ns/1ps
module shmac_unit_tb;
  import shmac_pkg::*;
  logic        clk, srst, op_valid, ft, st, load, rv, rl;
  shmac_op_t   op;
  logic [31:0] a, b, c, lo, hi, d_lo, d_hi;
  logic [63:0] load_val, pair, last;
  int          error_cnt = 0;
  int          cmp_count = 0;

  shmac_unit shmac_unit_inst (.clk(clk), .srst(srst), .op_valid(op_valid), .op(op), .first_top_sel(ft),
    .second_top_sel(st), .first_operand_reg(a), .second_operand_reg(b), .accum_operand_reg(c),
    .acc_low_word_in(lo), .acc_high_word_in(hi), .result_valid(rv), .result_is_long(rl),
    .dest_low_word_reg(d_lo), .dest_high_word_reg(d_hi));
  shmac_regfile_model shmac_regfile_model_inst (.clk(clk), .load(load), .load_val(load_val),
    .wb_en(rv & rl), .wb_val({d_hi, d_lo}), .pair_lo(lo), .pair_hi(hi));

  // ----------------------------------------------------------------
  // Reference and helpers
  // ----------------------------------------------------------------
  function automatic logic [63:0] ref_calc(shmac_op_t o, logic [31:0] x, y, w, logic [63:0] p, logic fs, ss);
    logic signed [63:0] xh, xl, yh, yl, sp, s;
    xh = $signed(x[31:16]);
    xl = $signed(x[15:0]);
    yh = $signed(y[31:16]);
    yl = $signed(y[15:0]);
    sp = p;
    case (o)
      SHMAC_OP_DUAL_MAC32:         s = $signed(w) + xh * yh + xl * yl;
      SHMAC_OP_DUAL_MAC32_SWAPPED: s = $signed(w) + xh * yl + xl * yh;
      SHMAC_OP_WORD_MAC64:         s = sp + $signed(x) * $signed(y);
      SHMAC_OP_HALF_SELECT_MAC64:  s = sp + (fs ? xh : xl) * (ss ? yh : yl);
      SHMAC_OP_DUAL_MAC64:         s = sp + xh * yh + xl * yl;
      default:                     s = sp + xh * yl + xl * yh;
    endcase
    return (o inside {SHMAC_OP_DUAL_MAC32, SHMAC_OP_DUAL_MAC32_SWAPPED}) ? {32'h0, s[31:0]} : s;
  endfunction : ref_calc

  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic load_pair(input logic [63:0] v);
    load = 1;
    load_val = v;
    pair = v;
    @(posedge clk); #1;
    load = 0;
  endtask : load_pair

  // Issues one request and judges the answer one cycle later; leaves op_valid high
  task automatic step(input shmac_op_t o, input logic [31:0] x, y, w, input logic fs, ss);
    logic lng;
    lng = !(o inside {SHMAC_OP_DUAL_MAC32, SHMAC_OP_DUAL_MAC32_SWAPPED});
    op_valid = 1; op = o; a = x; b = y; c = w; ft = fs; st = ss;
    last = ref_calc(o, x, y, w, pair, fs, ss);
    @(posedge clk); #1;
    check(64'({rv, rl}), {62'h0, 1'b1, lng});
    check({d_hi, d_lo}, last);
  endtask : step

  // Drops the strobe with changed operands; results must hold
  task automatic idle();
    op_valid = 0; a = ~a; b = ~b;
    @(posedge clk); #1;
    check(64'(rv), 64'h0);
    check({d_hi, d_lo}, last);
    if (rl === 1'b1) pair = last;
  endtask : idle

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic test_reset();
    check({d_hi, d_lo}, 64'h0);
    check(64'({rv, rl}), 64'h0);
  endtask : test_reset

  task automatic test_dual32();
    step(SHMAC_OP_DUAL_MAC32, 32'h7fff_8000, 32'h7fff_8000, 32'h7fff_ffff, 0, 0);
    step(SHMAC_OP_DUAL_MAC32_SWAPPED, 32'h0003_fffe, 32'h0005_0007, 32'h0000_0010, 0, 0);
    idle();
  endtask : test_dual32

  task automatic test_word64();
    load_pair(64'h7fff_ffff_ffff_ffff);
    step(SHMAC_OP_WORD_MAC64, 32'h0000_0001, 32'h0000_0001, 32'h0, 0, 0);
    idle();
    step(SHMAC_OP_WORD_MAC64, 32'h8000_0000, 32'h7fff_ffff, 32'h0, 0, 0);
    idle();
  endtask : test_word64

  task automatic test_half_select();
    logic [31:0] mx, my;
    for (int i = 0; i < 8; i++) begin
      mx = i[2] ? (i[0] ? 32'h0000_ffff : 32'hffff_0000) : 32'h0;
      my = i[2] ? (i[1] ? 32'h0000_ffff : 32'hffff_0000) : 32'h0;
      load_pair(64'hffff_ffff_0000_0005);
      step(SHMAC_OP_HALF_SELECT_MAC64, 32'h8001_7ffe ^ mx, 32'hc000_0003 ^ my, 32'h0, i[0], i[1]);
      idle();
    end
  endtask : test_half_select

  task automatic test_dual64();
    load_pair(64'h0000_0001_ffff_fff0);
    step(SHMAC_OP_DUAL_MAC64, 32'h7fff_8000, 32'h7fff_8000, 32'h0, 0, 0);
    idle();
    load_pair(64'h8000_0000_0000_0000);
    step(SHMAC_OP_DUAL_MAC64_SWAPPED, 32'h0003_fffe, 32'hfffb_0007, 32'h0, 0, 0);
    idle();
  endtask : test_dual64

  task automatic report_and_stop();
    $display("Checks: %0d, mismatches: %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : report_and_stop

  initial begin
    clk = 0;
    forever #2.5 clk = ~clk;
  end

  initial begin
    srst = 1; op_valid = 0; op = SHMAC_OP_DUAL_MAC32; ft = 0; st = 0; load = 0;
    a = 0; b = 0; c = 0; load_val = 0; pair = 0; last = 0;
    repeat (3) @(posedge clk);
    #1 srst = 0;
    test_reset();
    test_dual32();
    test_word64();
    test_half_select();
    test_dual64();
    report_and_stop();
  end

  initial begin
    #10000;
    error_cnt++;
    report_and_stop();
  end
endmodule : shmac_unit_tb
